// file: verilog/pwm_timer_pkg.sv
package pwm_timer_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned CNT_W  = 8;
    localparam int unsigned PRE_W  = 10;

    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_CTRL_B = 6'h18;
    localparam logic [5:0] IDX_CTRL_A = 6'h19;
    localparam logic [5:0] IDX_COUNT  = 6'h1A;
    localparam logic [5:0] IDX_CMP_A  = 6'h1B;
    localparam logic [5:0] IDX_CMP_B  = 6'h1C;
    localparam logic [5:0] IDX_FLAGS  = 6'h1D;

    // control register a fields
    localparam int unsigned CA_MODE_A_HI = 7;
    localparam int unsigned CA_MODE_A_LO = 6;
    localparam int unsigned CA_MODE_B_HI = 5;
    localparam int unsigned CA_MODE_B_LO = 4;
    localparam logic [7:0]  CA_WR_MASK   = 8'hF3;
    localparam logic [7:0]  CTRL_RESET   = 8'h00;

    // control register b fields
    localparam int unsigned CB_FORCE_A  = 7;
    localparam int unsigned CB_FORCE_B  = 6;
    localparam int unsigned CB_WAVE_HI  = 3;
    localparam int unsigned CB_CS_HI    = 2;
    localparam logic [7:0]  CB_RD_MASK  = 8'h0F;

    // flag register bits, write one to clear
    localparam int unsigned FLG_OVF = 0;
    localparam int unsigned FLG_MA  = 1;
    localparam int unsigned FLG_MB  = 2;
    localparam logic [2:0]  FLG_RESET = 3'h0;

    localparam logic [7:0] BOTTOM = 8'h00;
    localparam logic [7:0] MAX    = 8'hFF;
    localparam logic [7:0] ONE    = 8'h01;

    localparam logic [2:0] MODE_NORMAL  = 3'h0;
    localparam logic [2:0] MODE_PC_MAX  = 3'h1;
    localparam logic [2:0] MODE_CTC     = 3'h2;
    localparam logic [2:0] MODE_FAST_MX = 3'h3;
    localparam logic [2:0] MODE_PC_CMP  = 3'h5;
    localparam logic [2:0] MODE_FAST_CP = 3'h7;

    localparam logic [1:0] COM_OFF    = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR  = 2'h2;
    localparam logic [1:0] COM_SET    = 2'h3;

    localparam logic [2:0] CS_DIV1    = 3'h1;
    localparam logic [2:0] CS_DIV8    = 3'h2;
    localparam logic [2:0] CS_DIV64   = 3'h3;
    localparam logic [2:0] CS_DIV256  = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [9:0] PRE_M8     = 10'h007;
    localparam logic [9:0] PRE_M64    = 10'h03F;
    localparam logic [9:0] PRE_M256   = 10'h0FF;
    localparam logic [9:0] PRE_M1024  = 10'h3FF;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic {DIR_UP, DIR_DOWN} dir_t;

    function automatic logic is_pc(input logic [2:0] m);
        return (m == MODE_PC_MAX) || (m == MODE_PC_CMP);
    endfunction

    function automatic logic is_fast(input logic [2:0] m);
        return (m == MODE_FAST_MX) || (m == MODE_FAST_CP);
    endfunction

endpackage

// file: verilog/wave_if.sv
`timescale 1ns/1ps
interface wave_if;
    import pwm_timer_pkg::*;
    logic             tick;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] cmp;
    logic [CNT_W-1:0] top;
    dir_t             dir;
    logic             pc_mode;
    logic             fast_mode;
    logic             hi_bit;
    logic [1:0]       com;
    logic             force_cmp;
    logic             at_bottom;
    logic             oc;
    logic             connected;

    modport timer (output tick, cnt, cmp, top, dir, pc_mode, fast_mode, hi_bit, com,
                   force_cmp, at_bottom, input oc, connected);
    modport unit  (input tick, cnt, cmp, top, dir, pc_mode, fast_mode, hi_bit, com,
                   force_cmp, at_bottom, output oc, connected);
endinterface : wave_if

// file: verilog/compare_out_unit.sv
`timescale 1ns/1ps
module compare_out_unit
    import pwm_timer_pkg::*;
#(
    parameter bit PWM_TOGGLE = 1'b1
) (
    input wire logic clk,
    input wire logic sys_rst,
    wave_if.unit     w
);

    logic oc_q;
    logic oc_d;
    logic up_seen_q;
    logic match;
    logic up_match;
    logic pwm;
    logic toggle_ok;
    logic top_hold;
    logic inv;

    assign match     = w.tick && (w.cnt == w.cmp);
    // at bottom the counter still carries the down direction, yet a match there opens a slope
    assign up_match  = match && ((w.dir == DIR_UP) || (w.cnt == BOTTOM));
    assign pwm       = w.pc_mode || w.fast_mode;
    assign toggle_ok = !pwm || (PWM_TOGGLE && w.hi_bit);
    assign w.connected = w.com[1] || (w.com[0] && toggle_ok);
    assign top_hold  = pwm && w.com[1] && (w.cmp == w.top);
    assign inv       = w.com[0];
    assign w.oc      = oc_q;

    always_comb begin
        oc_d = oc_q;
        if (!pwm) begin
            if (match || w.force_cmp) begin
                case (w.com)
                    COM_TOGGLE: oc_d = ~oc_q;
                    COM_CLEAR:  oc_d = 1'b0;
                    COM_SET:    oc_d = 1'b1;
                    default:    oc_d = oc_q;
                endcase
            end
        end else if (w.com == COM_TOGGLE) begin
            if (toggle_ok && match) begin
                oc_d = ~oc_q;
            end
        end else if (w.com[1] && w.fast_mode) begin
            if (match && !top_hold) begin
                oc_d = inv;
            end
            if (w.at_bottom) begin
                oc_d = ~inv;
            end
        end else if (w.com[1]) begin
            if (top_hold) begin
                if (w.tick && (w.cnt == w.top)) begin
                    oc_d = ~inv;
                end
            end else if (up_match) begin
                oc_d = inv;
            end else if (match) begin
                oc_d = ~inv;
            end else if (w.at_bottom && !up_seen_q) begin
                oc_d = inv;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            oc_q <= 1'b0;
        end else begin
            oc_q <= oc_d;
        end
    end

    // remembers whether the rising slope produced its match, so bottom can fill it in
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            up_seen_q <= 1'b0;
        end else if (w.at_bottom) begin
            up_seen_q <= 1'b0;
        end else if (up_match) begin
            up_seen_q <= 1'b1;
        end
    end

    a_pc_clear_up: assert property (@(posedge clk) disable iff (sys_rst)
        (w.pc_mode && w.com == COM_CLEAR && up_match && !top_hold) |=> !oc_q)
        else $error("output not cleared on rising match");

    a_pc_set_up: assert property (@(posedge clk) disable iff (sys_rst)
        (w.pc_mode && w.com == COM_SET && up_match && !top_hold) |=> oc_q)
        else $error("inverted output not set on rising match");

    a_fast_bottom: assert property (@(posedge clk) disable iff (sys_rst)
        (w.fast_mode && w.com[1] && w.at_bottom) |=> (oc_q == !$past(inv)))
        else $error("fast mode bottom action missing");

    a_plain_toggle: assert property (@(posedge clk) disable iff (sys_rst)
        (!pwm && w.com == COM_TOGGLE && match) |=> (oc_q != $past(oc_q)))
        else $error("no toggle on match in plain mode");

endmodule : compare_out_unit

// file: verilog/pwm_timer.sv
`timescale 1ns/1ps
module pwm_timer
    import pwm_timer_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output      logic              s_axi_awready,
    input  wire logic [DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output      logic              s_axi_wready,
    output      logic [1:0]        s_axi_bresp,
    output      logic              s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output      logic              s_axi_arready,
    output      logic [DATA_W-1:0] s_axi_rdata,
    output      logic [1:0]        s_axi_rresp,
    output      logic              s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              port_out_a,
    input  wire logic              port_dir_a,
    input  wire logic              port_out_b,
    input  wire logic              port_dir_b,
    output      logic              compare_out_a_o,
    output      logic              compare_out_a_oe,
    output      logic              compare_out_b_o,
    output      logic              compare_out_b_oe
);

    logic [7:0]            ctrl_a_q;
    logic [7:0]            ctrl_b_q;
    logic [2:0]            flags_q;
    logic [2:0]            flags_set;
    logic [2:0]            flags_clr;
    logic [CNT_W-1:0]      cnt_q;
    logic [CNT_W-1:0]      cnt_d;
    dir_t                  dir_q;
    dir_t                  dir_d;
    logic [1:0][CNT_W-1:0] cmp_buf_q;
    logic [1:0][CNT_W-1:0] cmp_act_q;
    logic [1:0]            force_q;
    logic [PRE_W-1:0]      pre_q;
    logic                  tick;
    logic [2:0]            wave_mode;
    logic                  pc;
    logic                  fast;
    logic                  ctc;
    logic [CNT_W-1:0]      top_val;
    logic                  at_top;
    logic                  at_bottom;
    logic                  cmp_load;
    logic [1:0]            match;
    logic [1:0]            oc;
    logic [1:0]            conn;
    logic [1:0][1:0]       com_mode;

    logic                  aw_full_q;
    logic                  w_full_q;
    logic [ADDR_W-1:0]     aw_addr_q;
    logic [7:0]            w_byte_q;
    logic                  w_lane_q;
    logic                  wr_go;
    logic [5:0]            wr_idx;
    logic                  wr_hit;
    logic [DATA_W-1:0]     rd_word;
    logic                  rd_hit;
    logic [5:0]            rd_idx;
    logic [5:0]            rd_idx_q;

    // ------------------------------------------------------------------ bus slave
    assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_full_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_go         = aw_full_q && w_full_q && !s_axi_bvalid;
    assign wr_idx        = aw_addr_q[ADDR_W-1:2];
    assign wr_hit        = (aw_addr_q[1:0] == 2'h0) &&
                           ((wr_idx >= IDX_CTRL_B) && (wr_idx <= IDX_FLAGS));

    // address and data are taken independently; the write happens once both are held
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            aw_full_q <= 1'b0;
            aw_addr_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_full_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            w_full_q <= 1'b0;
            w_byte_q <= '0;
            w_lane_q <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full_q <= 1'b1;
            w_byte_q <= s_axi_wdata[7:0];
            w_lane_q <= s_axi_wstrb[0];
        end else if (wr_go) begin
            w_full_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    assign rd_idx = s_axi_araddr[ADDR_W-1:2];

    always_comb begin
        rd_word = '0;
        rd_hit  = (s_axi_araddr[1:0] == 2'h0);
        case (rd_idx)
            IDX_CTRL_A: rd_word[7:0] = ctrl_a_q & CA_WR_MASK;
            IDX_CTRL_B: rd_word[7:0] = ctrl_b_q & CB_RD_MASK;
            IDX_COUNT:  rd_word[7:0] = cnt_q;
            IDX_CMP_A:  rd_word[7:0] = cmp_buf_q[0];
            IDX_CMP_B:  rd_word[7:0] = cmp_buf_q[1];
            IDX_FLAGS:  rd_word[2:0] = flags_q;
            default:    rd_hit       = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
            rd_idx_q     <= '0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_hit ? rd_word : '0;
            s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            rd_idx_q     <= rd_idx;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------ registers
    function automatic logic wr_to(input logic [5:0] idx);
        return wr_go && wr_hit && w_lane_q && (wr_idx == idx);
    endfunction

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_a_q <= CTRL_RESET;
        end else if (wr_to(IDX_CTRL_A)) begin
            ctrl_a_q <= w_byte_q & CA_WR_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_b_q <= CTRL_RESET;
        end else if (wr_to(IDX_CTRL_B)) begin
            ctrl_b_q <= w_byte_q & CB_RD_MASK;
        end
    end

    // force strobes live for one cycle and never read back
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            force_q <= 2'h0;
        end else if (wr_to(IDX_CTRL_B)) begin
            force_q <= {w_byte_q[CB_FORCE_B], w_byte_q[CB_FORCE_A]};
        end else begin
            force_q <= 2'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cmp_buf_q <= '0;
        end else if (wr_to(IDX_CMP_A)) begin
            cmp_buf_q[0] <= w_byte_q;
        end else if (wr_to(IDX_CMP_B)) begin
            cmp_buf_q[1] <= w_byte_q;
        end
    end

    // plain modes load at once; pwm modes wait for top so a period is never torn
    assign cmp_load = pc ? (tick && at_top) :
                      fast ? (tick && (cnt_q == top_val)) : 1'b1;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cmp_act_q <= '0;
        end else if (cmp_load) begin
            cmp_act_q <= cmp_buf_q;
        end
    end

    assign flags_clr = wr_to(IDX_FLAGS) ? w_byte_q[2:0] : 3'h0;
    assign flags_set = {match[1], match[0],
                        pc ? at_bottom :
                        (tick && (cnt_q == (fast ? top_val : MAX)))};

    // a hardware event in the clearing cycle survives the clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flags_q <= FLG_RESET;
        end else begin
            flags_q <= (flags_q & ~flags_clr) | flags_set;
        end
    end

    // ------------------------------------------------------------------ prescaler
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + 10'h001;
        end
    end

    // the prescaled tick is a clock enable; everything stays on clk
    always_comb begin
        case (ctrl_b_q[CB_CS_HI:0])
            CS_DIV1:    tick = 1'b1;
            CS_DIV8:    tick = (pre_q & PRE_M8) == PRE_M8;
            CS_DIV64:   tick = (pre_q & PRE_M64) == PRE_M64;
            CS_DIV256:  tick = (pre_q & PRE_M256) == PRE_M256;
            CS_DIV1024: tick = (pre_q & PRE_M1024) == PRE_M1024;
            default:    tick = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------ counter
    assign wave_mode = {ctrl_b_q[CB_WAVE_HI], ctrl_a_q[1:0]};
    assign pc        = is_pc(wave_mode);
    assign fast      = is_fast(wave_mode);
    assign ctc       = (wave_mode == MODE_CTC);
    assign top_val   = ((wave_mode == MODE_PC_CMP) || (wave_mode == MODE_FAST_CP) || ctc) ?
                       cmp_act_q[0] : MAX;
    assign at_top    = (dir_q == DIR_UP) && (cnt_q >= top_val);
    assign at_bottom = tick && pc && (cnt_d == BOTTOM) && (cnt_q != BOTTOM);
    assign com_mode  = {ctrl_a_q[CA_MODE_B_HI:CA_MODE_B_LO],
                        ctrl_a_q[CA_MODE_A_HI:CA_MODE_A_LO]};

    always_comb begin
        cnt_d = cnt_q;
        dir_d = dir_q;
        if (wr_to(IDX_COUNT)) begin
            cnt_d = w_byte_q;
        end else if (tick && pc) begin
            if (at_top) begin
                dir_d = DIR_DOWN;
                cnt_d = (cnt_q == BOTTOM) ? BOTTOM : cnt_q - ONE;
            end else if (dir_q == DIR_UP) begin
                cnt_d = cnt_q + ONE;
            end else if (cnt_q == BOTTOM) begin
                dir_d = DIR_UP;
                cnt_d = (top_val == BOTTOM) ? BOTTOM : ONE;
            end else begin
                cnt_d = cnt_q - ONE;
            end
        end else if (tick) begin
            dir_d = DIR_UP;
            cnt_d = ((fast || ctc) && (cnt_q == top_val)) ? BOTTOM : cnt_q + ONE;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_q <= BOTTOM;
            dir_q <= DIR_UP;
        end else begin
            cnt_q <= cnt_d;
            dir_q <= dir_d;
        end
    end

    // ------------------------------------------------------------------ compare outputs
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        wave_if w ();
        assign w.tick      = tick;
        assign w.cnt       = cnt_q;
        assign w.cmp       = cmp_act_q[ch];
        assign w.top       = top_val;
        assign w.dir       = dir_q;
        assign w.pc_mode   = pc;
        assign w.fast_mode = fast;
        assign w.hi_bit    = ctrl_b_q[CB_WAVE_HI];
        assign w.com       = com_mode[ch];
        assign w.force_cmp = force_q[ch] && !(pc || fast);
        assign w.at_bottom = pc ? at_bottom : (fast && tick && (cnt_q == top_val));
        assign oc[ch]      = w.oc;
        assign conn[ch]    = w.connected;
        assign match[ch]   = tick && (cnt_q == cmp_act_q[ch]);

        // only channel a may toggle in the pwm modes, and only in modes 5 and 7
        compare_out_unit #(
            .PWM_TOGGLE (1'(ch == 0))
        ) u_unit (
            .clk     (clk),
            .sys_rst (sys_rst),
            .w       (w)
        );
    end

    // the pin is only driven when software has set its direction to output
    assign compare_out_a_o  = conn[0] ? oc[0] : port_out_a;
    assign compare_out_a_oe = port_dir_a;
    assign compare_out_b_o  = conn[1] ? oc[1] : port_out_b;
    assign compare_out_b_oe = port_dir_b;

    a_top_dwell: assert property (@(posedge clk) disable iff (sys_rst)
        (pc && tick && at_top && cnt_q == top_val && top_val != BOTTOM && !wr_go)
        |=> (dir_q == DIR_DOWN && cnt_q == $past(cnt_q) - ONE))
        else $error("counter did not leave top after one tick");

    a_ovf_bottom: assert property (@(posedge clk) disable iff (sys_rst)
        at_bottom |=> (flags_q[FLG_OVF] && cnt_q == BOTTOM))
        else $error("overflow flag not set at bottom");

    a_top_fixed: assert property (@(posedge clk) disable iff (sys_rst)
        (wave_mode == MODE_PC_MAX) |-> (top_val == MAX))
        else $error("fixed top is not max");

    a_reserved_zero: assert property (@(posedge clk) disable iff (sys_rst)
        (s_axi_rvalid && rd_idx_q == IDX_CTRL_A) |-> (s_axi_rdata[3:2] == 2'h0))
        else $error("reserved bits read nonzero");

    a_pin_to_port: assert property (@(posedge clk) disable iff (sys_rst)
        (ctrl_a_q[CA_MODE_A_HI:CA_MODE_A_LO] == COM_OFF) |-> (compare_out_a_o == port_out_a))
        else $error("disconnected channel drives the pin");

endmodule : pwm_timer

// file: sim/pin_model.sv
`timescale 1ns/1ps
module pin_model (
    input  wire logic drv,
    input  wire logic drv_en,
    output      logic pin
);
    // a released pin floats to the pull-up level, never to the last value
    assign pin = drv_en ? drv : 1'b1;
endmodule // pin_model

// file: sim/pwm_timer_tb.sv
`timescale 1ns/1ps
module pwm_timer_tb;
    import pwm_timer_pkg::*;
    logic        clk, sys_rst, awv, wv, bry, arv, rry, pout, pdir;
    logic        awr, wr_r, bv, arr, rv, oa, oa_oe, pin, ob, ob_oe;
    logic [7:0]  awa, ara;
    logic [31:0] wd, rd, rng;
    logic [1:0]  br, rr;
    int          err_count, checks_done, cycles, hi, edg;
    logic [1:0]  com_t [7] = '{2'h2, 2'h2, 2'h2, 2'h3, 2'h3, 2'h0, 2'h1};
    logic [7:0]  cmp;

    pwm_timer uut (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wr_r), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .port_out_a(pout),
        .port_dir_a(pdir), .port_out_b(pout), .port_dir_b(pdir), .compare_out_a_o(oa),
        .compare_out_a_oe(oa_oe), .compare_out_b_o(ob), .compare_out_b_oe(ob_oe));
    pin_model pm (.drv(oa), .drv_en(oa_oe), .pin(pin));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    // high clocks in one 510-tick period of mode 1 at divide by one
    function automatic int exp_hi(input logic [1:0] com, input logic [7:0] c, input logic p);
        if (com == COM_CLEAR) return 2 * c;
        if (com == COM_SET) return 510 - 2 * c;
        return p ? 510 : 0;
    endfunction

    // high clocks in one 256-tick fast period with top at max
    function automatic int exp_fast(input logic inv, input logic [7:0] c);
        return inv ? 255 - c : c + 1;
    endfunction

    // counts high samples and level changes over n clocks at the pin
    task automatic measure(input int n);
        logic last;
        hi = 0;
        edg = 0;
        @(negedge clk);
        last = pin;
        repeat (n) begin
            @(negedge clk);
            hi += pin;
            edg += (pin != last);
            last = pin;
        end
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        if (err_count == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // each channel is released at the rising edge that takes it; bready stays up
    task automatic wreg(input logic [5:0] idx, input logic [7:0] d);
        logic b;
        awa <= {idx, 2'h0};
        wd <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        do begin
            @(posedge clk);
            b = bv;
            if (awr && awv) awv <= 1'b0;
            if (wr_r && wv) wv <= 1'b0;
        end while (!b);
    endtask

    task automatic rreg(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] r);
        logic v;
        ara <= {idx, 2'h0};
        arv <= 1'b1;
        rry <= 1'b1;
        do begin
            @(posedge clk);
            v = rv;
            d = rd;
            r = rr;
            if (arr && arv) arv <= 1'b0;
        end while (!v);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            err_count++;
            end_of_test();
        end
    end

    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        {awv, wv, bry, arv, rry, pout, pdir, awa, ara, wd} = '0;
        {err_count, checks_done, cycles} = '0;
        rng = 32'h4D;
        sys_rst = 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        pdir <= 1'b1;
        rreg(IDX_CTRL_A, d, r);
        chk(d, 32'h0);
        wreg(IDX_CTRL_A, 8'hFF);
        rreg(IDX_CTRL_A, d, r);
        chk(d, 32'hF3);
        rreg(6'h3F, d, r);
        chk(r, RESP_SLVERR);
        wreg(IDX_CTRL_B, 8'h01);
        for (int i = 0; i < 7; i++) begin
            rng = xs(rng);
            cmp = (i == 0 || i == 4) ? 8'h00 : (i == 1) ? 8'hFF : 8'(rng % 254 + 1);
            pout <= i[0];
            wreg(IDX_CMP_A, cmp);
            wreg(IDX_CTRL_A, {com_t[i], 6'h01});
            repeat (1100) @(posedge clk);
            measure(510);
            chk(hi, exp_hi(com_t[i], cmp, i[0]));
            chk(oa_oe, pdir);
        end
        // fast pwm, top at max: random clear, then compare at top both ways
        for (int j = 0; j < 3; j++) begin
            rng = xs(rng);
            cmp = (j == 0) ? 8'(rng % 254 + 1) : MAX;
            wreg(IDX_CMP_A, cmp);
            wreg(IDX_CTRL_A, {(j == 1) ? COM_SET : COM_CLEAR, 6'h03});
            repeat (600) @(posedge clk);
            measure(256);
            chk(hi, exp_fast(j == 1, cmp));
        end
        // normal mode toggles once per 256 ticks
        rng = xs(rng);
        wreg(IDX_CMP_A, 8'(rng % 254 + 1));
        wreg(IDX_CTRL_A, {COM_TOGGLE, 6'h00});
        repeat (300) @(posedge clk);
        measure(512);
        chk(edg, 2);
        // mode 5 at divide by 8: channel a toggles once per 2*top ticks, b stays on the port
        rng = xs(rng);
        cmp = 8'(rng % 40 + 20);
        pout <= 1'b1;
        wreg(IDX_CMP_A, cmp);
        wreg(IDX_CTRL_B, 8'h0A);
        wreg(IDX_CTRL_A, 8'h51);
        repeat (2200) @(posedge clk);
        measure(32 * cmp);
        chk(edg, 2);
        chk(ob, pout);
        pdir <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        chk(pin, 1'b1);
        chk({oa_oe, ob_oe}, 2'h0);
        wreg(IDX_FLAGS, 8'h01);
        repeat (1000) @(posedge clk);
        rreg(IDX_FLAGS, d, r);
        chk(d[0], 1'b1);
        end_of_test();
    end
endmodule // pwm_timer_tb
